//--- verilog/eesi_defs.svh
// Constants for the two-wire serial memory slave front end.
// Assumes inclusion by bare name from the top module.
`ifndef EESI_DEFS_SVH
`define EESI_DEFS_SVH
// ==========================================
// Address byte fields
`define EESI_PREFIX_MAIN 4'ha
`define EESI_PREFIX_IDPG 4'hb
`define EESI_RW_BIT 0
`define EESI_BLOCK_BIT 1
`define EESI_STRAP_LO_BIT 2
`define EESI_STRAP_HI_BIT 3
// ==========================================
// Reset values and timing
`define EESI_ERASED 8'hff
`define EESI_TWR_US 4000
`define EESI_CLK_MHZ 20
`define EESI_TWR_CYCLES (`EESI_TWR_US * `EESI_CLK_MHZ)
`endif

//--- verilog/eesi_pkg.sv
// Types shared by the serial memory slave front end.
// Assumes nothing beyond a SystemVerilog compiler.
package eesi_pkg;
	// Slave protocol states
	typedef enum logic [3:0] {
		EESI_IDLE = 4'h0,
		EESI_DEV = 4'h1,
		EESI_DEV_ACK = 4'h2,
		EESI_WORD = 4'h3,
		EESI_WORD_ACK = 4'h4,
		EESI_WDATA = 4'h5,
		EESI_WDATA_ACK = 4'h6,
		EESI_RDATA = 4'h7,
		EESI_RACK = 4'h8
	} eesi_state_t;
endpackage

//--- verilog/eesi_top.sv
// Two-wire slave front end of a 512x8 memory with a 16-byte id page.
// Assumes SCL and SDA pins sampled on CLK; SDA wire resolved outside.
`timescale 1ns/1ns
`include "eesi_defs.svh"

module eesi_top
	import eesi_pkg::*;
#(
	parameter int WR_CYCLES = `EESI_TWR_CYCLES,
	parameter int FIFO_DEPTH = 2
)
(
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	// Two-wire bus pins
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// Strap and protect pins
	input wire logic STRAP_SELECT_LOW,
	input wire logic STRAP_SELECT_HIGH,
	input wire logic WP,
	// Status
	output logic BUSY,
	output logic STANDBY
);
	localparam int WCW = $clog2(WR_CYCLES + 1);
	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int FW = 13;

	// ==========================================
	// Parameter checks
	generate
		if (WR_CYCLES < 1 || FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
		begin : g_bad
			$error("eesi_top: unsupported parameter values");
		end
	endgenerate

	// Next address inside the same 16-byte page
	function automatic logic [8:0] page_next(input logic [8:0] a);
		page_next = {a[8:4], a[3:0] + 4'h1};
	endfunction

	// ==========================================
	// Pin synchronisers
	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic wp_m, wp_s, slo_m, slo_s, shi_m, shi_s;

	// Two flops per pin, third flop for edges
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			{scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3f;
			{wp_m, wp_s, slo_m, slo_s, shi_m, shi_s} <= 6'h00;
		end
		else if (CE)
		begin
			{scl_m, scl_s, scl_d} <= {SCL_IN, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {SDA_IN, sda_m, sda_s};
			{wp_m, wp_s} <= {WP, wp_m};
			{slo_m, slo_s, shi_m, shi_s} <= {STRAP_SELECT_LOW, slo_m,
				STRAP_SELECT_HIGH, shi_m};
		end

	// ==========================================
	// Bus events
	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_det = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

	// ==========================================
	// State and storage
	eesi_state_t state;
	logic [2:0] bitcnt;
	logic [7:0] shreg;
	logic [8:0] addr;
	logic rd_dir, id_sel, blk, byte_done, mack, wrote, oe;
	logic busy, commit_req;
	logic [WCW-1:0] wcnt;
	logic [7:0] mem [0:511];
	logic [7:0] idpg [0:15];
	logic [7:0] pbuf [0:15];
	logic [15:0] pmask;
	logic [4:0] pg_hi;
	logic pg_id;

	// Address byte decode
	wire [7:0] rx_byte = {shreg[6:0], sda_s};
	wire dev_pfx_main = shreg[7:4] == `EESI_PREFIX_MAIN;
	wire dev_pfx_id = shreg[7:4] == `EESI_PREFIX_IDPG;
	wire strap_ok = shreg[`EESI_STRAP_HI_BIT] == shi_s &&
		shreg[`EESI_STRAP_LO_BIT] == slo_s;
	wire dev_match = (dev_pfx_main | dev_pfx_id) & strap_ok;
	wire rx_state = state == EESI_DEV || state == EESI_WORD ||
		state == EESI_WDATA;
	wire [7:0] rd_data = id_sel ? idpg[addr[3:0]] : mem[addr];

	// ==========================================
	// Write buffer of FIFO_DEPTH entries, two by default
	logic [FW-1:0] fifo_mem [0:FIFO_DEPTH-1];
	logic [PW-1:0] wr_ptr, rd_ptr;
	logic [PW:0] fcount;
	wire fifo_in_ready = fcount != (PW+1)'(FIFO_DEPTH);
	wire fifo_out_valid = fcount != '0;
	wire fifo_out_ready = ~busy;
	wire fifo_push = scl_fall & byte_done & state == EESI_WDATA &
		fifo_in_ready;
	wire fifo_pop = fifo_out_valid & fifo_out_ready;
	wire [FW-1:0] fifo_head = fifo_mem[rd_ptr];

	// Buffer pointers and storage
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fcount <= '0;
		end
		else if (CE)
		begin
			if (fifo_push)
				fifo_mem[wr_ptr] <= {id_sel, addr[3:0], shreg};
			wr_ptr <= wr_ptr + PW'(fifo_push);
			rd_ptr <= rd_ptr + PW'(fifo_pop);
			fcount <= fcount + (PW+1)'(fifo_push) - (PW+1)'(fifo_pop);
		end

	// ==========================================
	// Protocol engine
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			state <= EESI_IDLE;
			bitcnt <= 3'h0;
			shreg <= 8'h00;
			addr <= 9'h000;
			{rd_dir, id_sel, blk, byte_done, mack, wrote, oe} <= 7'h00;
			pg_hi <= 5'h00;
			pg_id <= 1'b0;
		end
		else if (CE)
		begin
			if (busy)
				state <= EESI_IDLE;
			else if (start_det)
			begin
				state <= EESI_DEV;
				{bitcnt, byte_done, mack, wrote, oe} <= 7'h00;
			end
			else if (stop_det)
			begin
				state <= EESI_IDLE;
				{wrote, oe} <= 2'b00;
			end
			else if (scl_rise)
			begin
				if (rx_state)
				begin
					shreg <= rx_byte;
					bitcnt <= bitcnt + 3'h1;
					byte_done <= bitcnt == 3'h7;
				end
				else if (state == EESI_RDATA)
				begin
					bitcnt <= bitcnt + 3'h1;
					byte_done <= bitcnt == 3'h7;
					if (bitcnt == 3'h7)
						addr <= addr + 9'h001;
				end
				else if (state == EESI_RACK)
				begin
					mack <= ~sda_s;
					if (sda_s)
						state <= EESI_IDLE;
				end
			end
			else if (scl_fall)
			begin
				byte_done <= 1'b0;
				case (state)
					EESI_DEV:
						if (byte_done)
						begin
							oe <= dev_match;
							state <= dev_match ? EESI_DEV_ACK : EESI_IDLE;
							rd_dir <= shreg[`EESI_RW_BIT];
							id_sel <= dev_pfx_id;
							blk <= shreg[`EESI_BLOCK_BIT];
						end
					EESI_DEV_ACK:
						if (rd_dir)
						begin
							state <= EESI_RDATA;
							shreg <= rd_data;
							oe <= ~rd_data[7];
						end
						else
						begin
							state <= EESI_WORD;
							oe <= 1'b0;
						end
					EESI_WORD:
						if (byte_done)
						begin
							oe <= 1'b1;
							state <= EESI_WORD_ACK;
							addr <= {blk, shreg};
							pg_hi <= {blk, shreg[7:4]};
							pg_id <= id_sel;
						end
					EESI_WDATA:
						if (byte_done)
						begin
							oe <= fifo_in_ready;
							state <= fifo_in_ready ? EESI_WDATA_ACK : EESI_IDLE;
							wrote <= wrote | fifo_in_ready;
							if (fifo_in_ready)
								addr <= page_next(addr);
						end
					EESI_WORD_ACK, EESI_WDATA_ACK:
					begin
						oe <= 1'b0;
						state <= EESI_WDATA;
					end
					EESI_RDATA:
						if (byte_done)
							oe <= 1'b0;
						else
						begin
							shreg <= {shreg[6:0], 1'b0};
							oe <= ~shreg[6];
						end
					EESI_RACK:
						if (mack)
						begin
							mack <= 1'b0;
							state <= EESI_RDATA;
							shreg <= rd_data;
							oe <= ~rd_data[7];
						end
					default:
						oe <= 1'b0;
				endcase
				if (state == EESI_RDATA && byte_done)
					state <= EESI_RACK;
			end
		end

	// ==========================================
	// Page buffer and write cycle
	wire start_ok = start_det & ~busy;
	wire commit_go = commit_req & ~fifo_out_valid & ~busy;

	// Page buffer fill from the write buffer
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
			pmask <= 16'h0000;
		else if (CE)
		begin
			if (fifo_pop)
			begin
				pbuf[fifo_head[11:8]] <= fifo_head[7:0];
				pmask[fifo_head[11:8]] <= 1'b1;
			end
			else if ((start_ok & ~commit_req) | (busy & wcnt == '0) |
				(commit_go & wp_s))
				pmask <= 16'h0000;
		end

	// Commit request and timed cycle
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			busy <= 1'b0;
			commit_req <= 1'b0;
			wcnt <= '0;
		end
		else if (CE)
		begin
			if (stop_det & wrote & ~busy)
				commit_req <= 1'b1;
			else if (commit_go)
				commit_req <= 1'b0;
			if (commit_go & ~wp_s & pmask != 16'h0000)
			begin
				busy <= 1'b1;
				wcnt <= WCW'(WR_CYCLES - 1);
			end
			else if (busy)
			begin
				wcnt <= wcnt - WCW'(1);
				if (wcnt == '0)
					busy <= 1'b0;
			end
		end

	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			for (int i = 0; i < 512; i++)
				mem[i] <= `EESI_ERASED;
			for (int j = 0; j < 16; j++)
				idpg[j] <= `EESI_ERASED;
		end
		else if (CE && busy && wcnt == '0)
			for (int k = 0; k < 16; k++)
				if (pmask[k])
				begin
					if (pg_id)
						idpg[k] <= pbuf[k];
					else
						mem[{pg_hi, 4'(k)}] <= pbuf[k];
				end

	// ==========================================
	// Output flops
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
		begin
			SDA_OUT <= 1'b0;
			SDA_OE <= 1'b0;
			BUSY <= 1'b0;
			STANDBY <= 1'b1;
		end
		else if (CE)
		begin
			SDA_OUT <= 1'b0;
			SDA_OE <= oe;
			BUSY <= busy;
			STANDBY <= state == EESI_IDLE && !busy && !commit_req &&
				!fifo_out_valid;
		end
endmodule // eesi_top

//--- sim/eesi_checker.sv
// Pin and status checker of the serial memory slave.
// Assumes binding onto eesi_top; sees its ports only.
`timescale 1ns/1ns
module eesi_checker
	import eesi_pkg::*;
#(
	parameter int WR_CYCLES = 20,
	parameter int FIFO_DEPTH = 2
)
(
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	// Bus pins
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	// Straps, protect, status
	input wire logic STRAP_SELECT_LOW,
	input wire logic STRAP_SELECT_HIGH,
	input wire logic WP,
	input wire logic BUSY,
	input wire logic STANDBY
);
	int unsigned busy_len;
	// ==========================================
	// Write cycle length counter
	always_ff @(posedge CLK or negedge RST_N)
		if (!RST_N)
			busy_len <= 0;
		// Enabled cycles only, as the design counts them
		else if (CE)
			busy_len <= BUSY ? busy_len + 1 : 0;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	// ==========================================
	// Pin and status relations
	a_out_zero: assert property (SDA_OUT == 1'b0)
		else $error("data pin driven high");
	a_power_up: assert property ($rose(RST_N) |-> STANDBY && !BUSY)
		else $error("not idle after reset");
	a_busy_idle: assert property (BUSY |-> !STANDBY)
		else $error("idle while writing");
	a_busy_quiet: assert property (BUSY |-> !SDA_OE)
		else $error("bus answered while writing");
	a_idle_quiet: assert property (STANDBY |-> !SDA_OE)
		else $error("bus driven while idle");
	a_oe_scl_low: assert property ($changed(SDA_OE) |-> !$past(SCL_IN, 2))
		else $error("data changed with clock high");
	a_commit_stop: assert property ($rose(BUSY) |->
		SCL_IN && SDA_IN && !$past(SDA_IN, 8))
		else $error("write cycle not started by stop");
	a_wp_blocks: assert property ($rose(BUSY) |-> !WP && !$past(WP, 4))
		else $error("write cycle while protected");
	a_busy_len: assert property ($fell(BUSY) |->
		busy_len >= WR_CYCLES - 1 && busy_len <= WR_CYCLES + 1)
		else $error("write cycle length wrong");
	a_busy_bound: assert property (busy_len <= WR_CYCLES + 1)
		else $error("write cycle too long");
	// Main scenarios seen
	c_write: cover property ($fell(BUSY));
	c_ack: cover property ($rose(SDA_OE));
	c_wp: cover property (WP && SDA_OE);
	c_freeze: cover property (!CE && BUSY);
endmodule // eesi_checker

bind eesi_top eesi_checker #(.WR_CYCLES(WR_CYCLES), .FIFO_DEPTH(FIFO_DEPTH))
	eesi_checker_i (.CLK(CLK), .RST_N(RST_N), .CE(CE), .SCL_IN(SCL_IN),
	.SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
	.STRAP_SELECT_LOW(STRAP_SELECT_LOW),
	.STRAP_SELECT_HIGH(STRAP_SELECT_HIGH), .WP(WP), .BUSY(BUSY),
	.STANDBY(STANDBY));

//--- sim/eesi_master.sv
// Two-wire bus master model, SCL period 8 CLK.
// Assumes a pulled-up data wire resolved by the bench.
`timescale 1ns/1ns
module eesi_master
(
	// Clock and resolved data wire
	input wire logic clk,
	input wire logic sda_w,
	// Driven pins, data high means released
	output logic scl,
	output logic sda
);
	// Idle bus at time zero
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// Waits n clocks plus a small skew
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic start();
		// Full low phase, so a slave ack ends before the clock rises
		sda = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda = 1'b0;
		tick(4);
		scl = 1'b0;
	endtask
	// data moves in the low phase only
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		sda = b;
		tick(3);
		scl = 1'b1;
		tick(2);
		r = sda_w;
		tick(2);
		scl = 1'b0;
	endtask
	// Byte out MSB first, ack returned
	task automatic put(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(v[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic get(input logic ack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			v[i] = r;
		end
		bit_io(!ack, r);
	endtask
	task automatic stop();
		tick(1);
		sda = 1'b0;
		tick(3);
		scl = 1'b1;
		tick(4);
		sda = 1'b1;
		tick(4);
	endtask
endmodule // eesi_master

//--- sim/eesi_top_test.sv
// Bench: reset, writes, polls, reads, straps, protect.
// Assumes the master model and the bound checker.
`timescale 1ns/1ns
module eesi_top_test;
	import eesi_pkg::*;
	localparam int WRC = 300;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp = 1'b0;
	logic s_lo = 1'b0;
	logic s_hi = 1'b0;
	logic ce = 1'b1;
	logic scl, sda_m, sda_oe, sda_out, busy, standby, ak;
	logic [7:0] d;
	logic [7:0] mem [512];
	wire logic sda_w;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	// Pull-up wire
	assign sda_w = sda_m & ~sda_oe;
	always #25 clk = ~clk;
	eesi_master eesi_master_i (.clk(clk), .sda_w(sda_w), .scl(scl),
		.sda(sda_m));
	eesi_top #(.WR_CYCLES(WRC)) eesi_top_i (.CLK(clk), .RST_N(rst_n),
		.CE(ce), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out),
		.SDA_OE(sda_oe), .STRAP_SELECT_LOW(s_lo), .STRAP_SELECT_HIGH(s_hi),
		.WP(wp), .BUSY(busy), .STANDBY(standby));
	// ==========================================
	// Shared tasks
	task automatic chk(input logic [8:0] s, input logic [8:0] e);
		n_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic sel(input logic [7:0] a, input logic e);
		eesi_master_i.start();
		eesi_master_i.put(a, ak);
		chk(9'(ak), 9'(e));
	endtask
	task automatic wr(input logic [8:0] a, input int n, input logic [7:0] b);
		sel({6'h28, a[8], 1'b0}, 1'b1);
		eesi_master_i.put(a[7:0], ak);
		chk(9'(ak), 9'h001);
		for (int i = 0; i < n; i++)
		begin
			eesi_master_i.put(b + 8'(i), ak);
			chk(9'(ak), 9'h001);
			if (!wp)
				mem[{a[8:4], 4'(a[3:0] + i)}] = b + 8'(i);
		end
		eesi_master_i.stop();
	endtask
	task automatic wait_wr();
		int k;
		k = 0;
		eesi_master_i.tick(4);
		chk(9'(busy), 9'h001);
		sel(8'ha0, 1'b0);
		eesi_master_i.stop();
		while (busy !== 1'b0 && k < 2 * WRC)
		begin
			eesi_master_i.tick(1);
			k++;
		end
		chk(9'(busy), 9'h000);
		sel(8'ha0, 1'b1);
		eesi_master_i.stop();
	endtask
	task automatic rd(input logic [8:0] a, input int n);
		sel({6'h28, a[8], 1'b0}, 1'b1);
		eesi_master_i.put(a[7:0], ak);
		sel({6'h28, a[8], 1'b1}, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			eesi_master_i.get(i < n - 1, d);
			chk({1'b0, d}, {1'b0, mem[9'(a + i)]});
		end
		eesi_master_i.stop();
	endtask
	task automatic probe(input logic [7:0] a, input logic e);
		sel(a, e);
		if (!e)
		begin
			eesi_master_i.put(8'ha0, ak);
			chk(9'(ak), 9'h000);
		end
		eesi_master_i.stop();
	endtask
	// ==========================================
	// Scenarios
	task automatic t_basic();
		eesi_master_i.tick(3);
		chk(9'({standby, busy, sda_oe}), 9'h004);
		wr(9'h1ff, 1, 8'ha5);
		wait_wr();
		wr(9'h00e, 18, 8'h30);
		wait_wr();
		$display("t_basic done");
	endtask
	task automatic t_read();
		rd(9'h1fe, 3);
		sel(8'ha1, 1'b1);
		eesi_master_i.get(1'b0, d);
		chk({1'b0, d}, {1'b0, mem[9'h001]});
		eesi_master_i.stop();
		$display("t_read done");
	endtask
	task automatic t_addr();
		for (int i = 0; i < 4; i++)
		begin
			{s_hi, s_lo} = 2'(i);
			eesi_master_i.tick(4);
			probe({4'ha, 2'(i), 2'b00}, 1'b1);
			probe({4'ha, 2'(3 - i), 2'b00}, 1'b0);
			probe({4'hc, 2'(i), 2'b00}, 1'b0);
			probe({4'hb, 2'(i), 2'b00}, 1'b1);
		end
		{s_hi, s_lo} = 2'b00;
		$display("t_addr done");
	endtask
	task automatic t_wp();
		wp = 1'b1;
		wr(9'h1ff, 1, 8'h00);
		eesi_master_i.tick(8);
		chk(9'(busy), 9'h000);
		wp = 1'b0;
		rd(9'h1ff, 1);
		$display("t_wp done");
	endtask
	task automatic t_ce();
		wr(9'h010, 2, 8'h5a);
		eesi_master_i.tick(4);
		// Enable low must freeze the running write cycle
		ce = 1'b0;
		eesi_master_i.tick(2 * WRC);
		chk(9'(busy), 9'h001);
		ce = 1'b1;
		wait_wr();
		rd(9'h010, 2);
		$display("t_ce done");
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			end_of_test();
		end
	end
	// Main sequence
	initial
	begin
		foreach (mem[i])
			mem[i] = 8'hff;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_basic();
		t_read();
		t_addr();
		t_wp();
		t_ce();
		end_of_test();
	end
endmodule // eesi_top_test
